// *** hdl/iep_ctrl.sv ***
// Purpose: Interrupt enables, priorities and external pin detection
// Assumes: Source flags and pins are synchronous to clk_sys
// Notes: CPU takes a request with svcAck and ends it with svcReturn
`timescale 1ns/1ps
module iep_ctrl
  import iep_pkg::*;
(
  // Clock, reset and freeze
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Source flags and external pins
  input wire iep_sources_s srcFlags,
  input wire logic ext_request_pin_2,
  input wire logic ext_request_pin_3,
  // CPU side
  output iep_request_s cpuRequest,
  input wire logic svcAck,
  input wire logic svcReturn,
  // Event interrupt
  output logic irqOut
);
  logic [7:0] irq_priority_low;
  logic [7:0] ext_irq_control;
  logic [7:0] irq_enable_mask;
  logic [7:0] irq_priority_high_reg;
  logic [2:0] options;
  logic [2:0] evStatus;
  logic [2:0] evMask;
  logic [3:0] inService;
  logic pin2Prev;
  logic pin3Prev;

  logic busReq;
  logic wrByte;
  logic rdStatus;
  logic pwm_timer_irq_select;
  logic comparator_irq_enable;
  logic global_irq_enable;
  logic ext2Active;
  logic ext3Active;
  logic ext2Hit;
  logic ext3Hit;
  logic ext2SvcClr;
  logic ext3SvcClr;
  logic [NSRC-1:0] srcReq;
  logic [NSRC-1:0] srcLow;
  logic [NSRC-1:0] srcHigh;
  logic [1:0] curLevel;
  logic curBusy;
  iep_request_s next_request;
  logic [31:0] next_rdata;
  logic [2:0] evSet;

  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrByte = busReq && wb_we_i && wb_sel_i[0];
  assign rdStatus = busReq && !wb_we_i && wb_adr_i == OFS_STATUS;
  assign global_irq_enable = irq_enable_mask[EN_GLOBAL];
  assign comparator_irq_enable = irq_enable_mask[EN_COMP];
  assign pwm_timer_irq_select = options[OP_PWM_SEL];

  // Pin activity: high polarity flips both level and edge sense
  always_comb begin
    logic p2;
    logic p3;
    p2 = ext_request_pin_2 ^ ~options[OP_EXT2_HIGH];
    p3 = ext_request_pin_3 ^ ~options[OP_EXT3_HIGH];
    ext2Active = p2;
    ext3Active = p3;
    if (ext_irq_control[XC_EXT2_TYPE]) begin
      ext2Hit = p2 && !(pin2Prev ^ ~options[OP_EXT2_HIGH]);
    end else begin
      ext2Hit = p2;
    end
    if (ext_irq_control[XC_EXT3_TYPE]) begin
      ext3Hit = p3 && !(pin3Prev ^ ~options[OP_EXT3_HIGH]);
    end else begin
      ext3Hit = p3;
    end
  end

  // Previous pin levels for edge detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin2Prev <= 1'b1;
      pin3Prev <= 1'b1;
    end else if (clkEnable) begin
      pin2Prev <= ext_request_pin_2;
      pin3Prev <= ext_request_pin_3;
    end
  end

  // Per-slot request, low and high priority bits
  always_comb begin
    srcReq[0] = srcFlags.ext0 && irq_enable_mask[EN_EXT0];
    srcReq[1] = srcFlags.timer0 && irq_enable_mask[EN_TIMER0];
    srcReq[2] = srcFlags.ext1 && irq_enable_mask[EN_EXT1];
    srcReq[3] = srcFlags.timer1 && irq_enable_mask[EN_TIMER1];
    srcReq[4] = srcFlags.serial && irq_enable_mask[EN_SERIAL];
    if (comparator_irq_enable) begin
      srcReq[SLOT_SHARED2] = srcFlags.comparator;
    end else begin
      srcReq[SLOT_SHARED2] = ext_irq_control[XC_EXT2_PEND]
                             && ext_irq_control[XC_EXT2_EN];
    end
    if (pwm_timer_irq_select) begin
      srcReq[SLOT_SHARED3] = srcFlags.pwmTimer;
    end else begin
      srcReq[SLOT_SHARED3] = ext_irq_control[XC_EXT3_PEND]
                             && ext_irq_control[XC_EXT3_EN];
    end
    if (!global_irq_enable) begin
      srcReq = '0;
    end
    srcLow[4:0] = irq_priority_low[4:0];
    srcLow[SLOT_SHARED2] = comparator_irq_enable
                           ? irq_priority_low[PL_COMP]
                           : ext_irq_control[XC_EXT2_PRIO];
    srcLow[SLOT_SHARED3] = ext_irq_control[XC_EXT3_PRIO];
    srcHigh[4:0] = irq_priority_high_reg[4:0];
    srcHigh[SLOT_SHARED2] = irq_priority_high_reg[6];
    srcHigh[SLOT_SHARED3] = irq_priority_high_reg[7];
  end

  // Highest level now being serviced
  always_comb begin
    curBusy = |inService;
    curLevel = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (inService[l]) begin
        curLevel = l[1:0];
      end
    end
  end

  // Arbitration: level first, then polling order
  always_comb begin
    logic [1:0] lv;
    logic found;
    lv = 2'h0;
    found = 1'b0;
    next_request = '0;
    for (int l = 3; l >= 0; l--) begin
      for (int i = 0; i < NSRC; i++) begin
        lv = {srcHigh[i], srcLow[i]};
        if (!found && srcReq[i] && lv == l[1:0]) begin
          found = 1'b1;
          next_request.level = lv;
          next_request.source = i[2:0];
          next_request.vector = VEC_TABLE[i];
        end
      end
    end
    // Only a strictly higher level may interrupt a running handler
    next_request.valid = found
                         && (!curBusy || next_request.level > curLevel);
  end

  // Held request towards the CPU
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpuRequest <= '0;
    end else if (clkEnable) begin
      cpuRequest <= next_request;
      if (svcAck) begin
        cpuRequest.valid <= 1'b0;
      end
    end
  end

  // In-service levels; return ends the highest one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      inService <= '0;
    end else if (clkEnable) begin
      if (svcReturn && curBusy) begin
        inService[curLevel] <= 1'b0;
      end
      if (svcAck && cpuRequest.valid) begin
        inService[cpuRequest.level] <= 1'b1;
      end
    end
  end

  // Service start clears the shared pin flag only in its own mode
  assign ext2SvcClr = svcAck && cpuRequest.valid && !comparator_irq_enable
                      && cpuRequest.source == 3'(SLOT_SHARED2);
  assign ext3SvcClr = svcAck && cpuRequest.valid && !pwm_timer_irq_select
                      && cpuRequest.source == 3'(SLOT_SHARED3);

  // Enable, priority, options and event mask registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_enable_mask <= RST_ENABLE;
      irq_priority_low <= RST_PRIO_LOW;
      irq_priority_high_reg <= RST_PRIO_HIGH;
      options <= RST_OPTIONS;
      evMask <= RST_EVENTS;
    end else if (clkEnable && wrByte) begin
      case (wb_adr_i)
        OFS_ENABLE: irq_enable_mask <= wb_dat_i[7:0] & 8'hDF;
        OFS_PRIO_LOW: irq_priority_low <= wb_dat_i[7:0] & 8'h5F;
        OFS_PRIO_HIGH: irq_priority_high_reg <= wb_dat_i[7:0] & 8'hDF;
        OFS_OPTIONS: options <= wb_dat_i[2:0];
        OFS_MASK: evMask <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // External control register; hardware set wins over any clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_irq_control <= RST_EXT_CTRL;
    end else if (clkEnable) begin
      if (wrByte && wb_adr_i == OFS_EXT_CTRL) begin
        ext_irq_control <= wb_dat_i[7:0];
      end else begin
        if (ext2SvcClr) begin
          ext_irq_control[XC_EXT2_PEND] <= 1'b0;
        end
        if (ext3SvcClr) begin
          ext_irq_control[XC_EXT3_PEND] <= 1'b0;
        end
      end
      if (ext2Hit) begin
        ext_irq_control[XC_EXT2_PEND] <= 1'b1;
      end
      if (ext3Hit) begin
        ext_irq_control[XC_EXT3_PEND] <= 1'b1;
      end
    end
  end

  // Sticky events, cleared by reading the status register
  assign evSet = {svcAck && cpuRequest.valid, ext3Hit, ext2Hit};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evStatus <= RST_EVENTS;
      irqOut <= 1'b0;
    end else if (clkEnable) begin
      evStatus <= (rdStatus ? 3'h0 : evStatus) | evSet;
      irqOut <= |(((rdStatus ? 3'h0 : evStatus) | evSet) & evMask);
    end
  end

  // Read mux; unmapped offsets read zero and still acknowledge
  always_comb begin
    next_rdata = '0;
    case (wb_adr_i)
      OFS_ENABLE: next_rdata[7:0] = irq_enable_mask;
      OFS_PRIO_LOW: next_rdata[7:0] = irq_priority_low;
      OFS_EXT_CTRL: next_rdata[7:0] = ext_irq_control;
      OFS_PRIO_HIGH: next_rdata[7:0] = irq_priority_high_reg;
      OFS_OPTIONS: next_rdata[2:0] = options;
      OFS_STATUS: next_rdata[2:0] = evStatus;
      OFS_MASK: next_rdata[2:0] = evMask;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clkEnable) begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? next_rdata : 32'h0000_0000;
    end
  end
endmodule

// *** hdl/iep_pkg.sv ***
// Purpose: Shared constants and types of the interrupt enable/priority block
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Source index 0..6 follows the fixed polling order
package iep_pkg;
  localparam int NSRC = 7;
  // Register byte offsets
  localparam logic [7:0] OFS_PRIO_LOW = 8'hB8;
  localparam logic [7:0] OFS_EXT_CTRL = 8'hC0;
  localparam logic [7:0] OFS_ENABLE = 8'hE8;
  localparam logic [7:0] OFS_PRIO_HIGH = 8'hBC;
  localparam logic [7:0] OFS_OPTIONS = 8'hC4;
  localparam logic [7:0] OFS_STATUS = 8'hD0;
  localparam logic [7:0] OFS_MASK = 8'hD4;
  // Reset values
  localparam logic [7:0] RST_PRIO_LOW = 8'h00;
  localparam logic [7:0] RST_EXT_CTRL = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIO_HIGH = 8'h00;
  localparam logic [2:0] RST_OPTIONS = 3'h0;
  localparam logic [2:0] RST_EVENTS = 3'h0;
  // Enable register fields
  localparam int EN_GLOBAL = 7;
  localparam int EN_COMP = 6;
  localparam int EN_SERIAL = 4;
  localparam int EN_TIMER1 = 3;
  localparam int EN_EXT1 = 2;
  localparam int EN_TIMER0 = 1;
  localparam int EN_EXT0 = 0;
  // Priority low register fields
  localparam int PL_COMP = 6;
  // External control register fields
  localparam int XC_EXT3_PRIO = 7;
  localparam int XC_EXT3_EN = 6;
  localparam int XC_EXT3_PEND = 5;
  localparam int XC_EXT3_TYPE = 4;
  localparam int XC_EXT2_PRIO = 3;
  localparam int XC_EXT2_EN = 2;
  localparam int XC_EXT2_PEND = 1;
  localparam int XC_EXT2_TYPE = 0;
  // Options register fields
  localparam int OP_PWM_SEL = 0;
  localparam int OP_EXT2_HIGH = 1;
  localparam int OP_EXT3_HIGH = 2;
  // Event status fields
  localparam int EV_EXT2 = 0;
  localparam int EV_EXT3 = 1;
  localparam int EV_TAKEN = 2;
  // Vector table in polling order
  localparam logic [7:0] VEC_TABLE [NSRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B,
                                              8'h23, 8'h33, 8'h3B};
  localparam int SLOT_SHARED2 = 5;
  localparam int SLOT_SHARED3 = 6;

  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [2:0] source;
    logic [7:0] vector;
  } iep_request_s;

  typedef struct packed {
    logic timer0;
    logic timer1;
    logic serial;
    logic ext0;
    logic ext1;
    logic comparator;
    logic pwmTimer;
  } iep_sources_s;
endpackage

// *** test/iep_ctrl_asserts.sv ***
// Purpose: Port checks of the interrupt enable/priority block
// Assumes: One clock domain
// Notes: Attached by bind below
`timescale 1ns/1ps
module iep_ctrl_asserts
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sources, CPU link, event line
  input wire iep_sources_s srcFlags,
  input wire logic ext_request_pin_2,
  input wire logic ext_request_pin_3,
  input wire iep_request_s cpuRequest,
  input wire logic svcAck,
  input wire logic svcReturn,
  input wire logic irqOut
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEnable;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_once: assert property (s_req |=> s_pulse)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_upper_zero: assert property (wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_vector_map: assert property (cpuRequest.valid |->
    cpuRequest.vector == VEC_TABLE[cpuRequest.source])
    else $error("vector does not match source");
  chk_source_range: assert property (cpuRequest.valid |->
    cpuRequest.source <= 3'h6)
    else $error("source out of range");
  chk_take_drop: assert property (cpuRequest.valid && svcAck && clkEnable
    |=> !cpuRequest.valid)
    else $error("request stays after take");
  chk_reset_quiet: assert property ($fell(reset) |->
    !cpuRequest.valid && !irqOut && !wb_ack_o)
    else $error("outputs active after reset");
endmodule
bind iep_ctrl iep_ctrl_asserts i_iep_ctrl_asserts (.clk_sys(clk_sys),
  .reset(reset), .clkEnable(clkEnable), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .srcFlags(srcFlags),
  .ext_request_pin_2(ext_request_pin_2),
  .ext_request_pin_3(ext_request_pin_3), .cpuRequest(cpuRequest),
  .svcAck(svcAck), .svcReturn(svcReturn), .irqOut(irqOut));

// *** test/iep_cpu_model.sv ***
// Purpose: CPU core that takes requests and returns from handlers
// Assumes: Handler runs a fixed few cycles
// Notes: Acks only a valid request, one return per take
`timescale 1ns/1ps
module iep_cpu_model
  import iep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Request link
  input wire iep_request_s cpuRequest,
  output logic svcAck,
  output logic svcReturn,
  // Observation
  output logic [7:0] lastVector,
  output int takenCount
);
  int busy;
  always_ff @(posedge clk_sys) begin
    svcAck <= 1'b0;
    svcReturn <= 1'b0;
    if (reset) begin
      busy <= 0;
      takenCount <= 0;
      lastVector <= 8'h00;
    end else if (svcAck && cpuRequest.valid) begin
      lastVector <= cpuRequest.vector;
      takenCount <= takenCount + 1;
      busy <= 6;
    end else if (busy > 1) begin
      busy <= busy - 1;
    end else if (busy == 1) begin
      busy <= 0;
      svcReturn <= 1'b1;
    end else if (cpuRequest.valid) begin
      svcAck <= 1'b1;
    end
  end
endmodule

// *** test/irq_enable_priority_ctrl_bench.sv ***
// Purpose: Register and request tests of the interrupt block
// Assumes: clkEnable held high
// Notes: CPU side played by iep_cpu_model
`timescale 1ns/1ps
module irq_enable_priority_ctrl_bench;
  import iep_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, irqOut, svcAck, svcReturn;
  logic pin2 = 1'b1;
  logic pin3 = 1'b1;
  iep_sources_s src = '0;
  iep_request_s req;
  logic [7:0] lastVector;
  int takenCount, n0;
  int bad_count = 0;
  int total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  iep_ctrl i_iep_ctrl (.clk_sys(clk_sys), .reset(reset), .clkEnable(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .srcFlags(src), .ext_request_pin_2(pin2), .ext_request_pin_3(pin3),
    .cpuRequest(req), .svcAck(svcAck), .svcReturn(svcReturn),
    .irqOut(irqOut));
  iep_cpu_model i_iep_cpu_model (.clk_sys(clk_sys), .reset(reset),
    .cpuRequest(req), .svcAck(svcAck), .svcReturn(svcReturn),
    .lastVector(lastVector), .takenCount(takenCount));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk_sys);
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk_sys);
      t++;
    end
    q = rdat[7:0];
    if (t == 20) bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Wait for the CPU model to take a request, then check its vector
  task automatic take(input logic [7:0] e);
    int t;
    t = 0;
    while (takenCount == n0 && t < 50) begin
      @(posedge clk_sys);
      t++;
    end
    // A missed take must fail even when the old vector happens to match
    if (t == 50) bad_count++;
    cmp(lastVector, e);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(OFS_PRIO_LOW, 8'h00);
    rd(OFS_EXT_CTRL, 8'h00);
    rd(OFS_ENABLE, 8'h00);
    wr(OFS_ENABLE, 8'h7F);
    rd(OFS_ENABLE, 8'h5F);
    wr(OFS_PRIO_LOW, 8'hFF);
    rd(OFS_PRIO_LOW, 8'h5F);
    wr(OFS_EXT_CTRL, 8'hFF);
    rd(OFS_EXT_CTRL, 8'hFF);
    wr(OFS_EXT_CTRL, 8'h00);
    rd(OFS_EXT_CTRL, 8'h00);
    rd(8'h10, 8'h00);
    wr(OFS_PRIO_LOW, 8'h00);
    wr(OFS_ENABLE, 8'h03);
    src.ext0 <= 1'b1;
    src.timer0 <= 1'b1;
    repeat (10) @(posedge clk_sys);
    cmp(takenCount[7:0], 8'h00);
    n0 = takenCount;
    wr(OFS_ENABLE, 8'h83);
    take(8'h03);
    wr(OFS_ENABLE, 8'h03);
    wr(OFS_PRIO_LOW, 8'h02);
    repeat (10) @(posedge clk_sys);
    n0 = takenCount;
    wr(OFS_ENABLE, 8'h83);
    take(8'h0B);
    wr(OFS_ENABLE, 8'h03);
    wr(OFS_PRIO_LOW, 8'h01);
    wr(OFS_PRIO_HIGH, 8'h02);
    repeat (10) @(posedge clk_sys);
    n0 = takenCount;
    wr(OFS_ENABLE, 8'h83);
    take(8'h0B);
    wr(OFS_PRIO_HIGH, 8'h00);
    src <= '0;
    wr(OFS_ENABLE, 8'h80);
    wr(OFS_PRIO_LOW, 8'h00);
    wr(OFS_EXT_CTRL, 8'h05);
    repeat (10) @(posedge clk_sys);
    n0 = takenCount;
    pin2 <= 1'b0;
    take(8'h33);
    rd(OFS_EXT_CTRL, 8'h05);
    pin2 <= 1'b1;
    wr(OFS_ENABLE, 8'hC0);
    repeat (10) @(posedge clk_sys);
    n0 = takenCount;
    pin2 <= 1'b0;
    repeat (10) @(posedge clk_sys);
    cmp(takenCount[7:0], n0[7:0]);
    rd(OFS_EXT_CTRL, 8'h07);
    src.comparator <= 1'b1;
    take(8'h33);
    src <= '0;
    pin2 <= 1'b1;
    wr(OFS_ENABLE, 8'h80);
    wr(OFS_EXT_CTRL, 8'h40);
    wr(OFS_OPTIONS, 8'h01);
    repeat (10) @(posedge clk_sys);
    n0 = takenCount;
    pin3 <= 1'b0;
    repeat (10) @(posedge clk_sys);
    cmp(takenCount[7:0], n0[7:0]);
    wr(OFS_OPTIONS, 8'h00);
    take(8'h3B);
    pin3 <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wr(OFS_MASK, 8'h02);
    cmp({7'h00, irqOut}, 8'h01);
    rd(OFS_STATUS, 8'h07);
    cmp({7'h00, irqOut}, 8'h00);
    pin2 <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp({7'h00, irqOut}, 8'h00);
    pin3 <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp({7'h00, irqOut}, 8'h01);
    stop_test;
  end
endmodule
